// ==== uart_pkg.sv ====
package uart_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] STA_OFS = 4'h4;
   localparam logic [3:0] TXD_OFS = 4'h8;
   localparam logic [3:0] RXD_OFS = 4'hc;
   localparam logic [3:0] DIV_OFS = 4'h0;
   // ----------------------------------------
   // mode register fields
   // ----------------------------------------
   localparam int M_EN = 15;
   localparam int M_SIDL = 13;
   localparam int M_IR = 12;
   localparam int M_REQUEST_PIN_MODE = 11;
   localparam int M_PIN = 8;
   localparam int M_WAKE = 7;
   localparam int M_LPB = 6;
   localparam int M_ABD = 5;
   localparam int M_RXINV = 4;
   localparam int M_HS = 3;
   localparam int M_FMT = 1;
   localparam int M_STOP = 0;
   localparam logic [15:0] MODE_WMASK = 16'hbbff;
   // ----------------------------------------
   // status register fields
   // ----------------------------------------
   localparam int S_TXI1 = 15;
   localparam int S_TXPOL = 14;
   localparam int S_TXI0 = 13;
   localparam int S_BRK = 11;
   localparam int S_TXEN = 10;
   localparam int S_TXF = 9;
   localparam int S_TRANSMITTER_EMPTY_FLAG = 8;
   localparam int S_RXI = 6;
   localparam int S_ADDR = 5;
   localparam int S_RECEIVER_IDLE_FLAG = 4;
   localparam int S_PARITY_ERROR_FLAG = 3;
   localparam int S_FRAMING_ERROR_FLAG = 2;
   localparam int S_OVERRUN_ERROR_FLAG = 1;
   localparam int S_RXDA = 0;
   localparam logic [15:0] STA_WMASK = 16'he4e0;
   // ----------------------------------------
   // codes and counts
   // ----------------------------------------
   localparam logic [1:0] PIN_BCLK = 2'h3;
   localparam logic [1:0] PIN_CTS = 2'h2;
   localparam logic [1:0] PIN_RTS = 2'h1;
   localparam logic [1:0] FMT_9N = 2'h3;
   localparam logic [1:0] FMT_8O = 2'h2;
   localparam logic [1:0] FMT_8E = 2'h1;
   localparam logic [1:0] TXI_EMPTY = 2'h2;
   localparam logic [1:0] TXI_DONE = 2'h1;
   localparam logic [1:0] RXI_FULL = 2'h3;
   localparam logic [1:0] RXI_3Q = 2'h2;
   localparam logic [3:0] BREAK_ZEROS = 4'hc;
   localparam int FIFO_DEPTH = 4;
   localparam logic [4:0] TICKS_STD = 5'h10;
   localparam logic [4:0] TICKS_HS = 5'h04;
   localparam logic [8:0] SYNC_CHAR = 9'h055;
endpackage

// ==== uart_fifo.sv ====
`timescale 1ns/100ps
module uart_fifo
   import uart_pkg::*;
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] din,
   input wire logic pop,
   output logic [WIDTH-1:0] dout,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_reg;
   logic [AW-1:0] wr_reg;
   logic [AW:0] cnt_reg;
   wire do_push = push && (cnt_reg != DEPTH[AW:0]);
   wire do_pop = pop && (cnt_reg != '0);
   // head word and fill level
   assign dout = mem[rd_reg];
   assign count = cnt_reg;
   // storage array
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[wr_reg] <= din;
      end
   end
   // pointers and count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_reg <= '0;
         wr_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         rd_reg <= '0;
         wr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_push) wr_reg <= wr_reg + 1'b1;
         if (do_pop) rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end
endmodule // uart_fifo

// ==== uart_baud.sv ====
`timescale 1ns/100ps
module uart_baud
   import uart_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic run,
   input wire logic clear,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);
   logic [DIV_W-1:0] cnt_reg;
   wire wrap = (cnt_reg >= divisor);
   // free running divider, one tick per divisor+1 clocks
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (clear || !run) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else begin
         cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
         tick <= wrap;
      end
   end
endmodule // uart_baud

// ==== uart_mode_status_core.sv ====
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module uart_mode_status_core
   import uart_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sleep_mode,
   input wire logic serial_rx_pin,
   input wire logic clear_to_send_n,
   output logic serial_tx_pin,
   output logic serial_tx_oe_n,
   output logic request_to_send_n,
   output logic request_oe_n,
   output logic baud_clk_out,
   output logic baud_clk_oe_n,
   output logic tx_irq,
   output logic rx_irq,
   output logic wake_irq,
   output logic address_char
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0] mode_reg;
   logic [15:0] sta_reg;
   logic [DIV_W-1:0] div_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire wr_lo = req && wb_we_i && wb_sel_i[0];
   wire wr_hi = req && wb_we_i && wb_sel_i[1];
   wire wr_any = req && wb_we_i;
   wire sel_mode = (wb_adr_i == MODE_OFS);
   wire sel_sta = (wb_adr_i == STA_OFS);
   wire sel_txd = (wb_adr_i == TXD_OFS);
   wire sel_rxd = (wb_adr_i == RXD_OFS);
   wire rd_rxd = req && !wb_we_i && sel_rxd;
   wire wr_div = wr_any && sel_mode && wb_sel_i[2]; // divisor in upper half of word 0
   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   wire en = mode_reg[M_EN];
   wire [1:0] pins = mode_reg[M_PIN+:2];
   wire ir_on = mode_reg[M_IR] && !mode_reg[M_HS];
   wire nine = mode_reg[M_FMT+:2] == FMT_9N;
   wire par_on = (mode_reg[M_FMT+:2] == FMT_8O) || (mode_reg[M_FMT+:2] == FMT_8E);
   wire par_odd = mode_reg[M_FMT+:2] == FMT_8O;
   wire txen = sta_reg[S_TXEN] && en;
   wire cts_used = pins == PIN_CTS;
   wire [4:0] tpb = mode_reg[M_HS] ? TICKS_HS : TICKS_STD;
   // ----------------------------------------
   // baud generator
   // ----------------------------------------
   logic tick;
   uart_baud #(.DIV_W(DIV_W)) u_baud (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .run(en),
      .clear(wr_div),
      .divisor(div_reg),
      .tick(tick)
   );
   // ----------------------------------------
   // transmit buffer and serializer
   // ----------------------------------------
   typedef enum {TX_IDLE, TX_SHIFT} tx_state_e;
   tx_state_e tx_st;
   logic [11:0] tx_sh_reg;
   logic [4:0] tx_tick_reg;
   logic [3:0] tx_bits_reg;
   logic tx_line_reg;
   logic tx_brk_reg;
   logic [8:0] tx_head;
   logic [2:0] tx_cnt;
   wire tx_push = wr_any && sel_txd && txen;
   wire tx_start = (tx_st == TX_IDLE) && (tx_cnt != '0) && txen && !(cts_used && clear_to_send_n);
   wire tx_par = par_odd ? ~^tx_head[7:0] : ^tx_head[7:0];
   wire [3:0] tx_nbits = sta_reg[S_BRK] ? BREAK_ZEROS + 4'h1 :
                         4'h9 + {3'h0, nine | par_on} + {3'h0, mode_reg[M_STOP]};
   wire tx_bit_end = tick && (tx_tick_reg == tpb - 5'h01);
   wire tx_done = (tx_st == TX_SHIFT) && tx_bit_end && (tx_bits_reg == tx_nbits);
   uart_fifo #(.WIDTH(9)) u_txf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .flush(!txen),
      .push(tx_push),
      .din(wb_dat_i[8:0]),
      .pop(tx_start),
      .dout(tx_head),
      .count(tx_cnt)
   );
   // shift out start, data, parity, stop; break sends zeros
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tx_st <= TX_IDLE;
         tx_sh_reg <= '0;
         tx_tick_reg <= '0;
         tx_bits_reg <= '0;
         tx_line_reg <= 1'b1;
         tx_brk_reg <= 1'b0;
      end else if (!txen) begin
         tx_st <= TX_IDLE;
         tx_line_reg <= 1'b1;
      end else if (tx_start) begin
         tx_st <= TX_SHIFT;
         tx_brk_reg <= sta_reg[S_BRK];
         tx_sh_reg <= sta_reg[S_BRK] ? 12'h000 :
                      {2'h3, nine ? tx_head[8] : (par_on ? tx_par : 1'b1), tx_head[7:0], 1'b0};
         tx_tick_reg <= '0;
         tx_bits_reg <= '0;
      end else if (tx_st == TX_SHIFT && tick) begin
         tx_tick_reg <= tx_bit_end ? 5'h00 : tx_tick_reg + 5'h01;
         if (tx_tick_reg == 5'h00) begin
            tx_line_reg <= (tx_bits_reg > BREAK_ZEROS) ? 1'b1 : tx_sh_reg[0];
            tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
         end
         if (tx_bit_end) tx_bits_reg <= tx_bits_reg + 4'h1;
         if (tx_done) tx_st <= TX_IDLE;
      end
   end
   // ----------------------------------------
   // receive path
   // ----------------------------------------
   typedef enum {RX_IDLE, RX_SHIFT} rx_state_e;
   rx_state_e rx_st;
   logic [4:0] rx_tick_reg;
   logic [3:0] rx_bits_reg;
   logic [10:0] rx_sh_reg;
   logic rx_prev_reg;
   logic [10:0] rx_head;
   logic [2:0] rx_cnt;
   logic rx_flush;
   // loopback, infrared level inversion and polarity
   wire rx_pin_lvl = mode_reg[M_RXINV] ? ~serial_rx_pin : serial_rx_pin;
   wire rx_ir_lvl = ir_on ? ~rx_pin_lvl : rx_pin_lvl;
   wire rx_in = mode_reg[M_LPB] ? tx_line_reg : rx_ir_lvl;
   wire [3:0] rx_nbits = 4'h9 + {3'h0, nine | par_on};
   wire rx_sample = tick && (rx_tick_reg == {1'b0, tpb[4:1]});
   wire rx_last = rx_sample && (rx_bits_reg == rx_nbits);
   // bits enter at the top, so the field position follows the frame length
   wire [8:0] rx_data = nine ? rx_sh_reg[10:2] :
                        par_on ? {1'b0, rx_sh_reg[9:2]} : {1'b0, rx_sh_reg[10:3]};
   wire rx_parity_error_flag = par_on && ((^rx_sh_reg[10:2]) != par_odd);
   wire rx_framing_error_flag = !rx_in;
   wire rx_full = rx_cnt == FIFO_DEPTH[2:0];
   wire rx_push = rx_last && !rx_full;
   wire rx_ovf = rx_last && rx_full;
   uart_fifo #(.WIDTH(11)) u_rxf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .flush(rx_flush),
      .push(rx_push),
      .din({rx_parity_error_flag, rx_framing_error_flag, rx_data}),
      .pop(rd_rxd),
      .dout(rx_head),
      .count(rx_cnt)
   );
   // start detect, mid-bit sampling of each bit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_st <= RX_IDLE;
         rx_tick_reg <= '0;
         rx_bits_reg <= '0;
         rx_sh_reg <= '0;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rx_in;
         if (!en || rx_flush) begin
            rx_st <= RX_IDLE;
         end else if (rx_st == RX_IDLE) begin
            if (rx_prev_reg && !rx_in) begin // falling edge only, a low stop bit is no start
               rx_st <= RX_SHIFT;
               rx_tick_reg <= '0;
               rx_bits_reg <= '0;
            end
         end else if (tick) begin
            rx_tick_reg <= (rx_tick_reg == tpb - 5'h01) ? 5'h00 : rx_tick_reg + 5'h01;
            if (rx_sample) begin
               rx_sh_reg <= {rx_in, rx_sh_reg[10:1]};
               rx_bits_reg <= rx_bits_reg + 4'h1;
            end
            if (rx_last) rx_st <= RX_IDLE;
         end
      end
   end
   // ----------------------------------------
   // register file and hardware side effects
   // ----------------------------------------
   wire overrun_error_flag_clr = wr_lo && sel_sta && !wb_dat_i[S_OVERRUN_ERROR_FLAG] && sta_reg[S_OVERRUN_ERROR_FLAG];
   assign rx_flush = overrun_error_flag_clr;
   wire wake_fall = mode_reg[M_WAKE] && sleep_mode && rx_prev_reg && !rx_in;
   wire wake_rise = mode_reg[M_WAKE] && !rx_prev_reg && rx_in;
   wire abd_done = rx_push && mode_reg[M_ABD] && (rx_data == SYNC_CHAR);
   wire [15:0] mode_wr = {wr_hi ? wb_dat_i[15:8] : mode_reg[15:8], wr_lo ? wb_dat_i[7:0] : mode_reg[7:0]};
   wire [15:0] sta_wr = {wr_hi ? wb_dat_i[15:8] : sta_reg[15:8], wr_lo ? wb_dat_i[7:0] : sta_reg[7:0]};
   logic [15:0] mode_next;
   logic [15:0] sta_next;
   // mode register with self-clearing bits
   always_comb begin
      mode_next = (wr_any && sel_mode) ? (mode_wr & MODE_WMASK) : mode_reg;
      if (wake_rise) mode_next[M_WAKE] = 1'b0;
      if (abd_done) mode_next[M_ABD] = 1'b0;
   end
   // status register: writable bits, hardware flags, overrun set beats clear
   always_comb begin
      sta_next = (wr_any && sel_sta) ? (sta_wr & STA_WMASK) | (sta_reg & ~STA_WMASK) : sta_reg;
      if (tx_done && tx_brk_reg) sta_next[S_BRK] = 1'b0;
      if (overrun_error_flag_clr) sta_next[S_OVERRUN_ERROR_FLAG] = 1'b0;
      if (rx_ovf) sta_next[S_OVERRUN_ERROR_FLAG] = 1'b1;
      sta_next[S_TXF] = tx_cnt == FIFO_DEPTH[2:0];
      sta_next[S_TRANSMITTER_EMPTY_FLAG] = (tx_cnt == '0) && (tx_st == TX_IDLE) && !tx_start;
      sta_next[S_RECEIVER_IDLE_FLAG] = rx_st == RX_IDLE;
      sta_next[S_PARITY_ERROR_FLAG] = (rx_cnt != '0) && rx_head[10];
      sta_next[S_FRAMING_ERROR_FLAG] = (rx_cnt != '0) && rx_head[9];
      sta_next[S_RXDA] = rx_cnt != '0;
      sta_next[12] = 1'b0;
   end
   // registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= 16'h0000;
         sta_reg <= 16'h0110;
         div_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         sta_reg <= sta_next;
         if (wr_div) div_reg <= wb_dat_i[16+:DIV_W];
      end
   end
   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   wire [31:0] rd_mux = sel_mode ? {div_reg, mode_reg} :
                        sel_sta ? {16'h0000, sta_reg} :
                        sel_rxd ? {21'h000000, rx_head[10:9], rx_head[8:0]} : 32'h00000000;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         rdat_reg <= '0;
      end else begin
         ack_reg <= req;
         rdat_reg <= req ? rd_mux : rdat_reg;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   // ----------------------------------------
   // pins and events
   // ----------------------------------------
   logic bclk_reg;
   wire [1:0] txi = {sta_reg[S_TXI1], sta_reg[S_TXI0]};
   wire rxi_hit = (sta_reg[S_RXI+:2] == RXI_FULL) ? (rx_cnt == 3'h3) :
                  (sta_reg[S_RXI+:2] == RXI_3Q) ? (rx_cnt == 3'h2) : 1'b1;
   wire txi_hit = (txi == TXI_EMPTY) ? (tx_start && tx_cnt == 3'h1) :
                  (txi == TXI_DONE) ? (tx_done && tx_cnt == '0) : (txi == 2'h0) && tx_start;
   // infrared pulse: 3/16 of bit at start of each zero bit
   wire ir_pulse = !tx_line_reg && (tx_tick_reg < 5'h03);
   wire ir_idle = sta_reg[S_TXPOL];
   wire tx_level = ir_on ? (ir_pulse ? ~ir_idle : ir_idle) : tx_line_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         serial_tx_pin <= 1'b1;
         serial_tx_oe_n <= 1'b1;
         request_to_send_n <= 1'b1;
         request_oe_n <= 1'b1;
         baud_clk_out <= 1'b0;
         baud_clk_oe_n <= 1'b1;
         bclk_reg <= 1'b0;
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
         wake_irq <= 1'b0;
         address_char <= 1'b0;
      end else begin
         serial_tx_pin <= tx_level;
         serial_tx_oe_n <= !(txen && !mode_reg[M_LPB]);
         request_oe_n <= !(en && (pins == PIN_CTS || pins == PIN_RTS));
         // simplex asserts while sending, flow control while room remains
         request_to_send_n <= mode_reg[M_REQUEST_PIN_MODE] ? (tx_st == TX_IDLE) : rx_full;
         if (tick) bclk_reg <= ~bclk_reg;
         baud_clk_out <= bclk_reg && en && pins == PIN_BCLK;
         baud_clk_oe_n <= !(en && pins == PIN_BCLK);
         tx_irq <= txi_hit;
         rx_irq <= rx_push && rxi_hit;
         wake_irq <= wake_fall;
         address_char <= rx_push && nine && sta_reg[S_ADDR] && rx_data[8];
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   brk_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_done && tx_brk_reg && !wr_any) |=> !sta_reg[S_BRK]) else $error("break bit not cleared");
   tx_full_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_cnt == 3'h4) |=> sta_reg[S_TXF]) else $error("tx full flag wrong");
   transmitter_empty_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_st == TX_SHIFT) |=> !sta_reg[S_TRANSMITTER_EMPTY_FLAG]) else $error("tx empty flag set while busy");
   rxda_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(rx_cnt != '0) |=> sta_reg[S_RXDA]) else $error("data available flag missing");
   ovr_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_ovf |=> sta_reg[S_OVERRUN_ERROR_FLAG]) else $error("overrun not flagged");
   ovr_flush_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (overrun_error_flag_clr && !rx_ovf) |=> (rx_cnt == '0)) else $error("overrun clear did not flush");
   div_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_div |=> !tick ##1 (u_baud.cnt_reg <= 16'h0001)) else $error("baud timer not cleared");
   cts_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (cts_used && clear_to_send_n && tx_st == TX_IDLE) |=> (tx_st == TX_IDLE)) else $error("sent against cts");
   bclk_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (pins != PIN_BCLK) |=> !baud_clk_out) else $error("baud clock out of mode");
   cov_tx_c: cover property (@(posedge clk_sys) disable iff (!rstn) tx_done);
   cov_rx_c: cover property (@(posedge clk_sys) disable iff (!rstn) rx_push);
   cov_ovf_c: cover property (@(posedge clk_sys) disable iff (!rstn) rx_ovf);
   cov_brk_c: cover property (@(posedge clk_sys) disable iff (!rstn) tx_done && tx_brk_reg);
endmodule // uart_mode_status_core

// ==== uart_remote_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// remote serial terminal
// ----------------------------------------
module uart_remote_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] data,
   input wire logic bad_stop,
   input wire logic [15:0] bit_cycles,
   input wire logic hold_cts,
   output logic line,
   output logic clear_to_send_n,
   output logic busy
);
   logic [9:0] frame;
   // idle high line; sending granted unless held off
   initial begin
      line = 1'b1;
      busy = 1'b0;
   end
   assign clear_to_send_n = hold_cts;
   // start, eight data bits lsb first, stop (low when bad_stop)
   always begin
      do @(posedge clk_sys); while (go !== 1'b1);
      frame = {~bad_stop, data, 1'b0};
      busy <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         line <= frame[i];
         repeat (bit_cycles) @(posedge clk_sys);
      end
      line <= 1'b1;
      busy <= 1'b0;
   end
endmodule // uart_remote_model

// ==== uart_mode_status_core_tb_top.sv ====
`timescale 1ns/100ps
module uart_mode_status_core_tb_top;
   import uart_pkg::*;
   logic clk_sys, rstn, wb_cyc, wb_stb, wb_we, sleep_mode, go, bad_stop, busy, rx_line, cts_n;
   logic wb_ack_o, serial_tx_pin, serial_tx_oe_n, request_to_send_n, request_oe_n, baud_clk_out, baud_clk_oe_n;
   logic [3:0] wb_adr, wb_sel;
   logic [31:0] wb_dat, wb_dat_o, rd, seed;
   logic [7:0] tx_byte, d1, d2;
   int bad_count, n_tests;
   int n_txi, n_rxi, n_wk, lows;
   logic hold_cts, tx_irq, rx_irq, wake_irq;

   uart_mode_status_core #(.DIV_W(16)) uart_mode_status_core_inst (.clk_sys(clk_sys), .rstn(rstn),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_mode(sleep_mode),
      .serial_rx_pin(rx_line), .clear_to_send_n(cts_n), .serial_tx_pin(serial_tx_pin),
      .serial_tx_oe_n(serial_tx_oe_n), .request_to_send_n(request_to_send_n), .request_oe_n(request_oe_n),
      .baud_clk_out(baud_clk_out), .baud_clk_oe_n(baud_clk_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq),
      .wake_irq(wake_irq),
      .address_char());
   uart_remote_model uart_remote_model_inst (.clk_sys(clk_sys), .go(go), .data(tx_byte), .bad_stop(bad_stop),
      .bit_cycles(16'd32), .hold_cts(hold_cts), .line(rx_line), .clear_to_send_n(cts_n), .busy(busy));

   // event pulse counters
   always @(posedge clk_sys) begin
      if (tx_irq === 1'b1) n_txi++;
      if (rx_irq === 1'b1) n_rxi++;
      if (wake_irq === 1'b1) n_wk++;
   end

   // clock, 25 ns period
   always #12.5 clk_sys = ~clk_sys;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected rx data word: parity, framing, nine data bits
   function automatic logic [31:0] rx_exp(input logic [7:0] d, input logic fe);
      return {21'h0, 1'b0, fe, 1'b0, d};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one classic wishbone cycle, waits for ack
   task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat <= d;
      do begin
         @(posedge clk_sys);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 64);
      rd = wb_dat_o;
      if (k >= 64) begin
         bad_count++;
         $display("MISMATCH %0t no bus answer", $time);
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_sys);
   endtask
   // remote sends one character and the receiver settles
   task automatic send(input logic [7:0] d, input logic bs);
      tx_byte <= d;
      bad_stop <= bs;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 1000 && busy; k++) @(posedge clk_sys);
      repeat (48) @(posedge clk_sys);
   endtask

   task automatic complete_run;
      $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      complete_run;
   end

   // main sequence
   initial begin
      clk_sys = 1'b0; rstn = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 4'h0;
      wb_sel = 4'h0; wb_dat = 32'h0; sleep_mode = 1'b0; go = 1'b0; bad_stop = 1'b0; tx_byte = 8'h0;
      seed = 32'h983dce4a; bad_count = 0; n_tests = 0;
      n_txi = 0; n_rxi = 0; n_wk = 0; lows = 0; hold_cts = 1'b0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      wb(1'b0, STA_OFS, 4'hf, 32'h0);
      chk(rd, 32'h0110, "status reset");
      wb(1'b0, MODE_OFS, 4'h3, 32'h0);
      chk(rd & 32'hffff, 32'h0, "mode reset");
      chk({31'h0, serial_tx_oe_n}, 32'h1, "tx oe reset");
      $display("test reset done");
      wb(1'b1, MODE_OFS, 4'h7, {16'h0001, 16'h8000});
      wb(1'b1, STA_OFS, 4'h3, 32'h0400);
      chk({31'h0, serial_tx_oe_n}, 32'h0, "tx oe enabled");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wb(1'b1, TXD_OFS, 4'h3, seed & 32'hff);
      end
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h0300, 32'h0200, "tx full");
      wb(1'b1, STA_OFS, 4'h3, 32'h0);
      repeat (2) @(posedge clk_sys);
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h0700, 32'h0100, "tx abort");
      chk({31'h0, serial_tx_oe_n}, 32'h1, "tx oe off");
      $display("test transmit done");
      wb(1'b1, MODE_OFS, 4'h3, 32'h8200);
      chk({30'h0, request_oe_n, request_to_send_n}, 32'h0, "rts room");
      seed = lfsr(seed);
      d1 = seed[7:0];
      d2 = seed[15:8];
      send(d1, 1'b1);
      send(d2, 1'b0);
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h1f, 32'h15, "head framing_error_flag");
      wb(1'b0, RXD_OFS, 4'h3, 32'h0);
      chk(rd, rx_exp(d1, 1'b1), "rx first");
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h1f, 32'h11, "next head");
      wb(1'b0, RXD_OFS, 4'h3, 32'h0);
      chk(rd, rx_exp(d2, 1'b0), "rx second");
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h1f, 32'h10, "rx empty");
      $display("test receive done");
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         send((i == 0) ? 8'h00 : (i == 4) ? 8'hff : seed[7:0], 1'b0);
      end
      chk({31'h0, request_to_send_n}, 32'h1, "rts full");
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h3, 32'h3, "overrun set");
      wb(1'b1, STA_OFS, 4'h3, 32'h0);
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h3, 32'h0, "overrun flush");
      chk(n_rxi, 2 + FIFO_DEPTH, "rx irq count");
      $display("test overrun done");
      wb(1'b1, MODE_OFS, 4'h3, 32'h8080);
      sleep_mode <= 1'b1;
      send(8'h55, 1'b0);
      sleep_mode <= 1'b0;
      wb(1'b0, MODE_OFS, 4'h3, 32'h0);
      chk(rd & 32'h80, 32'h0, "wake self clear");
      chk(n_wk, 1, "wake pulse");
      wb(1'b0, RXD_OFS, 4'h3, 32'h0);
      chk(rd, rx_exp(8'h55, 1'b0), "wake char");
      $display("test wake done");
      wb(1'b1, MODE_OFS, 4'h3, 32'h8040);
      wb(1'b1, STA_OFS, 4'h3, 32'h0400);
      seed = lfsr(seed);
      wb(1'b1, TXD_OFS, 4'h3, seed & 32'hff);
      repeat (400) @(posedge clk_sys);
      wb(1'b0, RXD_OFS, 4'h3, 32'h0);
      chk(rd, rx_exp(seed[7:0], 1'b0), "loopback");
      $display("test loopback done");
      hold_cts <= 1'b1;
      wb(1'b1, MODE_OFS, 4'h3, 32'h8200);
      wb(1'b1, TXD_OFS, 4'h3, 32'h0);
      repeat (100) @(posedge clk_sys);
      wb(1'b0, STA_OFS, 4'h3, 32'h0);
      chk(rd & 32'h100, 32'h0, "cts holds char");
      chk({31'h0, serial_tx_pin}, 32'h1, "tx idle");
      hold_cts <= 1'b0;
      // zero byte: start plus eight data bits low, 32 clocks each
      repeat (400) begin
         @(posedge clk_sys);
         if (serial_tx_pin === 1'b0) lows++;
      end
      chk(lows, 9 * 32, "zero frame low time");
      chk(n_txi, 3, "tx irq count");
      $display("test clear to send done");
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, MODE_OFS, 4'h3, 32'h8000 | (c << 8));
         repeat (2) @(posedge clk_sys);
         chk({31'h0, baud_clk_oe_n}, {31'h0, c != 3}, "baud clock oe");
         chk({31'h0, request_oe_n}, {31'h0, !(c == 1 || c == 2)}, "request oe");
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wb(1'b1, MODE_OFS, 4'h3, seed & 32'hff5f);
         wb(1'b0, MODE_OFS, 4'h3, 32'h0);
         chk(rd & 32'hffff, seed & 32'hff5f & {16'h0, MODE_WMASK}, "mode readback");
      end
      $display("test pins and mode done");
      complete_run;
   end
endmodule // uart_mode_status_core_tb_top
